//--- src/vic_pkg.sv
// vic_pkg: constants, types and carriers of the vectored interrupt controller
package vic_pkg;
    // vector table shape
    localparam int NUM_VEC = 32;
    localparam int VEC_W = 5;
    localparam logic [NUM_VEC-1:0] NMI_MASK = 32'h0000_0002;
    localparam logic [NUM_VEC-1:0] RESET_MASK = 32'h0000_0001;
    localparam logic [7:0] VEC_NMI = 8'h01;
    localparam logic [7:0] CVT_NMI_VEC = 8'h01;
    localparam logic [7:0] CVT_LEVEL_ONE_VEC = 8'h02;
    localparam logic [7:0] CVT_LEVEL_ZERO_VEC = 8'h03;
    localparam logic [7:0] HP_VEC_NONE = 8'h00;
    localparam logic [15:0] APP_BASE = 16'h0000;
    localparam logic [15:0] BOOT_BASE = 16'h0200;
    localparam logic [15:0] VEC_ADDR_STEP = 16'h0002;

    // register indices; byte address is four times the index
    localparam logic [2:0] IDX_CTRLA = 3'h0;
    localparam logic [2:0] IDX_STATUS = 3'h1;
    localparam logic [2:0] IDX_PRIPTR = 3'h2;
    localparam logic [2:0] IDX_HPVEC = 3'h3;
    localparam logic [2:0] IDX_CCP = 3'h4;
    localparam logic [2:0] ADR_HI_ZERO = 3'h0;
    localparam logic [1:0] ADR_LO_ZERO = 2'h0;

    // field positions and reset values
    localparam int CTRLA_VBS_BIT = 6;
    localparam int CTRLA_CVT_BIT = 5;
    localparam int CTRLA_RR_BIT = 0;
    localparam int STAT_NMI_BIT = 7;
    localparam int STAT_L1_BIT = 1;
    localparam int STAT_L0_BIT = 0;
    localparam logic [7:0] REG_RESET = 8'h00;

    // unlock key value is arbitrary
    localparam logic [7:0] CCP_KEY = 8'h5A;
    localparam logic [2:0] CCP_WINDOW = 3'h4;

    // timing counts in clock cycles
    localparam bit LARGE_FLASH = 1'b1;
    localparam bit WIDE_PC = 1'b1;
    localparam logic [2:0] PUSH_CYC = 3'h2;
    localparam logic [2:0] JUMP_CYC = LARGE_FLASH ? 3'h3 : 3'h2;
    localparam logic [2:0] RETURN_FROM_INTERRUPT_CYC = WIDE_PC ? 3'h5 : 3'h4;
    localparam logic [2:0] WAKE_EXTRA_CYC = 3'h5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAKE = 3'b001,
        ST_EXTRA = 3'b010,
        ST_FINISH = 3'b011,
        ST_PUSH = 3'b100,
        ST_JUMP = 3'b101,
        ST_RETURN_FROM_INTERRUPT = 3'b110,
        ST_HOLD = 3'b111
    } vic_state_t;

    typedef enum logic [1:0] {
        LV_NONE = 2'b00,
        LV_ZERO = 2'b01,
        LV_ONE = 2'b10,
        LV_NMI = 2'b11
    } vic_level_t;

    typedef struct packed {
        logic gie;
        logic instr_end;
        logic sleep;
        logic wake_ready;
        logic return_from_interrupt;
    } vic_cpu_in_t;

    typedef struct packed {
        logic taken;
        logic busy;
        logic push;
        logic jump;
        logic pop;
        vic_level_t level;
        logic [7:0] vector;
        logic [15:0] vec_addr;
        logic base_select;
    } vic_cpu_out_t;
endpackage

//--- src/vic_top.sv
// vic_top: interrupt arbitration, entry/return sequencing, wishbone registers
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module vic_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [vic_pkg::NUM_VEC-1:0] irq_i,
    input wire vic_pkg::vic_cpu_in_t cpu_i,
    output vic_pkg::vic_cpu_out_t cpu_o
);
    import vic_pkg::*;

    // rotating pick: first pending vector after the pointer, wrapping
    function automatic logic [VEC_W:0] pick_rot(
        input logic [NUM_VEC-1:0] req,
        input logic [VEC_W-1:0] ptr
    );
        logic [VEC_W-1:0] idx;
        logic [VEC_W:0] res;
        res = '0;
        idx = '0;
        for (int i = 1; i <= NUM_VEC; i++) begin
            idx = VEC_W'(ptr + VEC_W'(i));
            if (!res[VEC_W] && req[idx]) begin
                res = {1'b1, idx};
            end
        end
        return res;
    endfunction

    logic vbs_q, cvt_q, rr_q;
    logic [7:0] ptr_q, hpvec_q;
    logic nmiex_q, l1ex_q, l0ex_q;
    logic [2:0] ccp_cnt_q, ccp_cnt_d;
    vic_state_t state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic ack_q;
    logic [31:0] dat_q;
    logic taken_q;
    vic_level_t lvl_q;
    logic [7:0] disp_q;
    logic [15:0] addr_q;

    // bus decode
    wire logic bus_req = wb_cyc_i & wb_stb_i;
    wire logic [2:0] bus_idx = wb_adr_i[4:2];
    wire logic bus_in_range = (wb_adr_i[7:5] == ADR_HI_ZERO) &&
                              (wb_adr_i[1:0] == ADR_LO_ZERO);
    // a write lands on the edge where the master sees ack
    wire logic bus_wr = bus_req & ack_q & wb_we_i & wb_sel_i[0] &
                        bus_in_range;
    wire logic wr_ctrla = bus_wr && (bus_idx == IDX_CTRLA);
    wire logic wr_ptr = bus_wr && (bus_idx == IDX_PRIPTR);
    wire logic wr_hpvec = bus_wr && (bus_idx == IDX_HPVEC);
    wire logic wr_ccp = bus_wr && (bus_idx == IDX_CCP);
    wire logic ccp_open = (ccp_cnt_q != 3'h0);

    wire logic [7:0] ctrla_rd = {1'b0, vbs_q, cvt_q, 4'h0, rr_q};
    wire logic [7:0] status_rd = {nmiex_q, 5'h00, l1ex_q, l0ex_q};
    wire logic [7:0] rd_byte =
        !bus_in_range ? 8'h00 :
        (bus_idx == IDX_CTRLA) ? ctrla_rd :
        (bus_idx == IDX_STATUS) ? status_rd :
        (bus_idx == IDX_PRIPTR) ? ptr_q :
        (bus_idx == IDX_HPVEC) ? hpvec_q : 8'h00;

    // request classification per vector
    logic [NUM_VEC-1:0] is_hp;
    for (genvar g = 0; g < NUM_VEC; g++) begin : g_cls
        // zero never matches since vector 0 is the reset slot
        assign is_hp[g] = (hpvec_q == 8'(g)) && (hpvec_q != HP_VEC_NONE) &&
                          !NMI_MASK[g] && !RESET_MASK[g];
    end

    // lines arrive already gated by each peripheral's enable
    wire logic [NUM_VEC-1:0] req_nmi = irq_i & NMI_MASK;
    wire logic [NUM_VEC-1:0] req_hp = irq_i & is_hp;
    wire logic [NUM_VEC-1:0] req_lo = irq_i & ~NMI_MASK & ~is_hp &
                                      ~RESET_MASK;

    // ptr 0 yields order 1,2,..: lowest address first
    wire logic [VEC_W:0] nmi_pick = pick_rot(req_nmi, VEC_W'(0));
    wire logic [VEC_W:0] hp_pick = pick_rot(req_hp, VEC_W'(0));
    wire logic [VEC_W:0] lo_pick =
        pick_rot(req_lo, ptr_q[VEC_W-1:0]);

    wire logic nmi_ok = nmi_pick[VEC_W] && !nmiex_q;
    wire logic hp_ok = hp_pick[VEC_W] && cpu_i.gie &&
                       !nmiex_q && !l1ex_q;
    wire logic lo_ok = lo_pick[VEC_W] && cpu_i.gie &&
                       !nmiex_q && !l1ex_q && !l0ex_q;
    wire logic win_any = nmi_ok | hp_ok | lo_ok;
    wire vic_level_t win_lvl = nmi_ok ? LV_NMI :
                               hp_ok ? LV_ONE :
                               lo_ok ? LV_ZERO : LV_NONE;
    wire logic [VEC_W-1:0] win_vec = nmi_ok ? nmi_pick[VEC_W-1:0] :
                                     hp_ok ? hp_pick[VEC_W-1:0] :
                                     lo_pick[VEC_W-1:0];
    wire logic [7:0] cvt_vec = (win_lvl == LV_NMI) ? CVT_NMI_VEC :
                               (win_lvl == LV_ONE) ? CVT_LEVEL_ONE_VEC :
                               CVT_LEVEL_ZERO_VEC;
    wire logic [7:0] disp_vec = cvt_q ? cvt_vec : 8'(win_vec);
    wire logic [15:0] base_addr = vbs_q ? BOOT_BASE : APP_BASE;
    wire logic [15:0] disp_addr = base_addr +
                                  (16'(disp_vec) * VEC_ADDR_STEP);

    logic accept, return_from_interrupt_go;

    // entry and return sequencing
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        accept = 1'b0;
        return_from_interrupt_go = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // a return being decoded goes first, it frees the level
                if (cpu_i.return_from_interrupt) begin
                    return_from_interrupt_go = 1'b1;
                    state_d = ST_RETURN_FROM_INTERRUPT;
                    cnt_d = RETURN_FROM_INTERRUPT_CYC - 3'h1;
                end else if (win_any) begin
                    accept = 1'b1;
                    state_d = cpu_i.sleep ? ST_WAKE : ST_FINISH;
                end
            end
            ST_WAKE: begin
                if (cpu_i.wake_ready) begin
                    state_d = ST_EXTRA;
                    cnt_d = WAKE_EXTRA_CYC - 3'h1;
                end
            end
            ST_EXTRA: begin
                if (cnt_q == 3'h0) begin
                    state_d = ST_PUSH;
                    cnt_d = PUSH_CYC - 3'h1;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            ST_FINISH: begin
                // multi-cycle instructions hold instr_end low until done
                if (cpu_i.instr_end) begin
                    state_d = ST_PUSH;
                    cnt_d = PUSH_CYC - 3'h1;
                end
            end
            ST_PUSH: begin
                if (cnt_q == 3'h0) begin
                    state_d = ST_JUMP;
                    cnt_d = JUMP_CYC - 3'h1;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            ST_JUMP: begin
                if (cnt_q == 3'h0) begin
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            ST_RETURN_FROM_INTERRUPT: begin
                if (cnt_q == 3'h0) begin
                    state_d = ST_HOLD;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            ST_HOLD: begin
                if (cpu_i.instr_end) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // unlock window counts instructions, not clock cycles
    always_comb begin
        ccp_cnt_d = ccp_cnt_q;
        if (wr_ccp && (wb_dat_i[7:0] == CCP_KEY)) begin
            ccp_cnt_d = CCP_WINDOW;
        end else if (ccp_open && cpu_i.instr_end) begin
            ccp_cnt_d = ccp_cnt_q - 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 3'h0;
            ccp_cnt_q <= 3'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ccp_cnt_q <= ccp_cnt_d;
        end
    end

    // control register; only the round robin bit is unprotected
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vbs_q <= REG_RESET[CTRLA_VBS_BIT];
            cvt_q <= REG_RESET[CTRLA_CVT_BIT];
            rr_q <= REG_RESET[CTRLA_RR_BIT];
        end else if (wr_ctrla) begin
            rr_q <= wb_dat_i[CTRLA_RR_BIT];
            if (ccp_open) begin
                vbs_q <= wb_dat_i[CTRLA_VBS_BIT];
                cvt_q <= wb_dat_i[CTRLA_CVT_BIT];
            end
        end
    end

    // hardware update of the pointer beats a same-cycle software write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_q <= REG_RESET;
        end else if (rr_q && accept && (win_lvl == LV_ZERO)) begin
            ptr_q <= 8'(win_vec);
        end else if (wr_ptr) begin
            ptr_q <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hpvec_q <= REG_RESET;
        end else if (wr_hpvec) begin
            hpvec_q <= wb_dat_i[7:0];
        end
    end

    // executing flags act as a level stack; return drops the top one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmiex_q <= REG_RESET[STAT_NMI_BIT];
            l1ex_q <= REG_RESET[STAT_L1_BIT];
            l0ex_q <= REG_RESET[STAT_L0_BIT];
        end else if (accept) begin
            nmiex_q <= nmiex_q | (win_lvl == LV_NMI);
            l1ex_q <= l1ex_q | (win_lvl == LV_ONE);
            l0ex_q <= l0ex_q | (win_lvl == LV_ZERO);
        end else if (return_from_interrupt_go) begin
            if (nmiex_q) begin
                nmiex_q <= 1'b0;
            end else if (l1ex_q) begin
                l1ex_q <= 1'b0;
            end else begin
                l0ex_q <= 1'b0;
            end
        end
    end

    // dispatch record handed to the core
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            taken_q <= 1'b0;
            lvl_q <= LV_NONE;
            disp_q <= 8'h00;
            addr_q <= 16'h0000;
        end else begin
            taken_q <= accept;
            if (accept) begin
                lvl_q <= win_lvl;
                disp_q <= disp_vec;
                addr_q <= disp_addr;
            end
        end
    end

    // classic wishbone: one wait state, ack dropped after one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req & ~ack_q;
            if (bus_req && !ack_q) begin
                dat_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    assign cpu_o.taken = taken_q;
    assign cpu_o.busy = (state_q != ST_IDLE);
    assign cpu_o.push = (state_q == ST_PUSH);
    assign cpu_o.jump = (state_q == ST_JUMP);
    assign cpu_o.pop = (state_q == ST_RETURN_FROM_INTERRUPT);
    assign cpu_o.level = lvl_q;
    assign cpu_o.vector = disp_q;
    assign cpu_o.vec_addr = addr_q;
    assign cpu_o.base_select = vbs_q;
endmodule

//--- verif/vic_core_model.sv
// vic_core_model: core-side stand-in driving instruction and wake timing
`timescale 1ns/1ps
module vic_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic gie_i,
    input wire logic sleep_i,
    input wire logic return_from_interrupt_i,
    input wire logic [1:0] ilen_i,
    output vic_pkg::vic_cpu_in_t core_o
);
    import vic_pkg::*;
    logic [1:0] cnt_q;
    logic [2:0] wake_q;
    logic end_w;
    // no instruction completes while asleep
    assign end_w = !sleep_i && cnt_q == ilen_i;
    always_ff @(posedge clk_i) begin
        if (rst_i || end_w) begin
            cnt_q <= 2'h0;
        end else if (!sleep_i) begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    // start-up delay, counted up to 7 while asleep and cleared while awake
    always_ff @(posedge clk_i) begin
        if (rst_i || !sleep_i) begin
            wake_q <= 3'h0;
        end else if (wake_q != 3'h7) begin
            wake_q <= wake_q + 3'h1;
        end
    end
    assign core_o = '{gie_i, end_w, sleep_i, wake_q == 3'h7, return_from_interrupt_i};
endmodule

//--- verif/vic_top_asserts.sv
// vic_top_asserts: entry, return and dispatch properties at the ports
`timescale 1ns/1ps
module vic_top_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire vic_pkg::vic_cpu_in_t cpu_i,
    input wire vic_pkg::vic_cpu_out_t cpu_o
);
    import vic_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_entry;
        $rose(cpu_o.push) |-> cpu_o.push[*2] ##1 cpu_o.jump[*3] ##1 !cpu_o.busy;
    endproperty
    a_entry: assert property (p_entry)
        else $error("entry push or jump length wrong");
    property p_taken;
        cpu_o.taken |=> !cpu_o.taken && cpu_o.busy;
    endproperty
    a_taken: assert property (p_taken)
        else $error("taken not a single pulse");
    property p_finish;
        cpu_o.taken && !cpu_i.instr_end |=> !cpu_o.push;
    endproperty
    a_finish: assert property (p_finish)
        else $error("push before instruction end");
    property p_wake;
        cpu_o.taken && cpu_i.sleep && cpu_i.wake_ready
            |=> !cpu_o.push[*5] ##1 cpu_o.push;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake entry extra cycles wrong");
    property p_pop;
        $rose(cpu_o.pop) |-> cpu_o.pop[*5] ##1 !cpu_o.pop;
    endproperty
    a_pop: assert property (p_pop)
        else $error("return pop length wrong");
    property p_mask;
        cpu_o.taken && cpu_o.level != LV_NMI |-> $past(cpu_i.gie);
    endproperty
    a_mask: assert property (p_mask)
        else $error("maskable taken with enable low");
    property p_addr;
        cpu_o.taken |-> cpu_o.vec_addr == (cpu_o.base_select ? BOOT_BASE
            : APP_BASE) + {7'h0, cpu_o.vector, 1'b0};
    endproperty
    a_addr: assert property (p_addr)
        else $error("vector address wrong");
    property p_nmi_vec;
        cpu_o.taken && cpu_o.level == LV_NMI |-> cpu_o.vector == CVT_NMI_VEC;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec)
        else $error("non-maskable vector wrong");
    property p_hold;
        $fell(cpu_o.pop) |-> cpu_o.busy && !cpu_o.taken;
    endproperty
    a_hold: assert property (p_hold)
        else $error("request served right after return");
endmodule

//--- verif/vic_top_bench.sv
// vic_top_bench: directed tests of the interrupt controller
`timescale 1ns/1ps
module vic_top_bench;
    import vic_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_req = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h0;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] irq = 32'h0;
    logic gie = 1'b1;
    logic sleep = 1'b0;
    logic return_from_interrupt = 1'b0;
    logic [1:0] ilen = 2'h0;
    logic [31:0] wb_rdat;
    logic [31:0] q;
    logic wb_ack;
    vic_cpu_in_t core;
    vic_cpu_out_t cpu_o;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    vic_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_req),
        .wb_stb_i(wb_req), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'h1), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .irq_i(irq), .cpu_i(core), .cpu_o(cpu_o));
    vic_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .gie_i(gie),
        .sleep_i(sleep), .return_from_interrupt_i(return_from_interrupt), .ilen_i(ilen), .core_o(core));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic finish_test();
        $display("compares %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard: whole run is a few hundred cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_req <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        // ack and read data are both sampled at the same rising edge
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_req <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wbx(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic setirq(input logic [31:0] v);
        @(posedge clk_i);
        irq <= v;
    endtask
    task automatic idle();
        do @(negedge clk_i); while (cpu_o.busy !== 1'b0);
    endtask
    task automatic take(input logic [25:0] e);
        do @(negedge clk_i); while (cpu_o.taken !== 1'b1);
        chk({6'h0, cpu_o.level, cpu_o.vector, cpu_o.vec_addr}, {6'h0, e});
        idle();
    endtask
    task automatic ret();
        @(posedge clk_i);
        return_from_interrupt <= 1'b1;
        @(posedge clk_i);
        return_from_interrupt <= 1'b0;
        idle();
    endtask
    task automatic none_taken();
        logic hit;
        hit = 1'b0;
        repeat (20) begin
            @(negedge clk_i);
            hit = hit | cpu_o.taken;
        end
        chk({31'h0, hit}, 32'h0);
    endtask
    task automatic t_reset();
        for (int i = 0; i < 8; i++) rdc(8'(i * 4), 32'h0);
        rdc(8'h01, 32'h0);
        chk({31'h0, cpu_o.base_select}, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_sched();
        setirq(32'h0000_0220);
        take({LV_ZERO, 8'h05, 16'h000A});
        rdc(8'h04, 32'h1);
        setirq(32'h0);
        ret();
        rdc(8'h04, 32'h0);
        wbx(1'b1, 8'h08, 32'h4);
        setirq(32'h0000_0048);
        take({LV_ZERO, 8'h06, 16'h000C});
        setirq(32'h0);
        ret();
        wbx(1'b1, 8'h08, 32'h0);
        wbx(1'b1, 8'h00, 32'h1);
        setirq(32'h0000_0048);
        take({LV_ZERO, 8'h03, 16'h0006});
        rdc(8'h08, 32'h3);
        ret();
        take({LV_ZERO, 8'h06, 16'h000C});
        setirq(32'h0);
        ret();
        wbx(1'b1, 8'h00, 32'h0);
        wbx(1'b1, 8'h08, 32'h0);
        $display("scheduling test done");
    endtask
    task automatic t_levels();
        wbx(1'b1, 8'h0C, 32'h9);
        setirq(32'h0000_0010);
        take({LV_ZERO, 8'h04, 16'h0008});
        setirq(32'h0000_0210);
        take({LV_ONE, 8'h09, 16'h0012});
        rdc(8'h04, 32'h3);
        setirq(32'h0);
        ret();
        rdc(8'h04, 32'h1);
        ret();
        wbx(1'b1, 8'h0C, 32'h0);
        gie <= 1'b0;
        setirq(32'h0000_0010);
        none_taken();
        setirq(32'h0000_0012);
        take({LV_NMI, 8'h01, 16'h0002});
        rdc(8'h04, 32'h80);
        gie <= 1'b1;
        none_taken();
        setirq(32'h0);
        ret();
        rdc(8'h04, 32'h0);
        $display("level test done");
    endtask
    task automatic t_protect();
        ilen <= 2'h2;
        wbx(1'b1, 8'h00, 32'h60);
        rdc(8'h00, 32'h0);
        wbx(1'b1, 8'h10, 32'h5A);
        wbx(1'b1, 8'h00, 32'h60);
        rdc(8'h00, 32'h60);
        chk({31'h0, cpu_o.base_select}, 32'h1);
        setirq(32'h0000_0080);
        take({LV_ZERO, 8'h03, 16'h0206});
        setirq(32'h0);
        ret();
        repeat (20) @(posedge clk_i);
        wbx(1'b1, 8'h00, 32'h0);
        rdc(8'h00, 32'h60);
        wbx(1'b1, 8'h10, 32'h5A);
        wbx(1'b1, 8'h00, 32'h0);
        ilen <= 2'h0;
        $display("protection test done");
    endtask
    task automatic t_sleep();
        int n;
        sleep <= 1'b1;
        repeat (10) @(posedge clk_i);
        setirq(32'h0000_0020);
        do @(negedge clk_i); while (cpu_o.taken !== 1'b1);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (cpu_o.push !== 1'b1);
        chk(32'(n), 32'h6);
        @(posedge clk_i);
        sleep <= 1'b0;
        irq <= 32'h0;
        idle();
        ret();
        $display("sleep test done");
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_sched();
        t_levels();
        t_protect();
        t_sleep();
        finish_test();
    end
endmodule
bind vic_top vic_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .cpu_i(cpu_i), .cpu_o(cpu_o));
